// *** tbce_timer.sv ***
// tbce_timer: time base and channel enable/polarity of a two-channel timer
// assumes an apb master on CORE_CLK_I; channel output levels arrive on pins
//
// Overview of operation
// - bit 2 enables channel 1 complementary output
// - bit 3 sets complementary level, 1 active low
// - lock level 2 or 3 freezes bit 3
// - bit 4 enables channel 2 like channel 1
// - bit 5 is channel 2 polarity
// - bit 7 channel 2 complementary polarity; rest reserved
// - counter tick is input clock over divider+1
// - zero reload value stops the counter
// - enable gates output or input capture
// - polarity 0 active high, 1 active low
`timescale 1ns/100ps
module tbce_timer
    import tbce_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic [31:0] PRDATA_O,
    input wire logic CH1_REF_I,
    input wire logic CH2_REF_I,
    input wire logic CH1_CAPTURE_I,
    input wire logic CH2_CAPTURE_I,
    output logic CH1_MAIN_OUTPUT_O,
    output logic CH1_COMPLEMENTARY_OUTPUT_O,
    output logic CH2_MAIN_OUTPUT_O,
    output logic CH2_COMPLEMENTARY_OUTPUT_O,
    output logic CH1_OUTPUT_OE_O,
    output logic CH1_COMP_OUTPUT_OE_O,
    output logic CH2_OUTPUT_OE_O,
    output logic [CNT_WIDTH-1:0] CH1_CAPTURE_VALUE_O,
    output logic [CNT_WIDTH-1:0] CH2_CAPTURE_VALUE_O,
    output logic COUNTER_TICK_O
);
    // ==========================================================
    // declarations
    logic [15:0] chan_en_q, chan_en_d;
    logic [CNT_WIDTH-1:0] count_value_q, count_value_d;
    logic [15:0] divider_value_q, divider_value_d;
    logic [CNT_WIDTH-1:0] reload_value_q, reload_value_d;
    logic [3:0] config_q, config_d;
    logic [31:0] rdata_d;
    logic slverr_d;
    logic wr_en, rd_en, known;
    logic counter_tick_clock;
    logic [1:0] ch1_ref_s, ch2_ref_s, cap1_s, cap2_s;
    logic cap1_prev_q, cap2_prev_q;
    logic [CNT_WIDTH-1:0] cap1_q, cap1_d, cap2_q, cap2_d;
    logic [6:0] out_d, out_q;

    function automatic logic pol_apply(input logic level, input logic pol);
        pol_apply = level ^ pol;
    endfunction : pol_apply

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == CHAN_EN_OFS) || (a == COUNT_OFS) || (a == DIVIDER_OFS) ||
            (a == RELOAD_OFS) || (a == CONFIG_OFS);
    endfunction : addr_known

    // ==========================================================
    // apb decode; zero wait states
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign known = addr_known(PADDR_I);

    // ==========================================================
    // prescaler
    tbce_prescaler #(
        .WIDTH(16)
    ) u_prescaler (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RESET_N_I),
        .div_i(divider_value_q),
        .tick_o(counter_tick_clock)
    );

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ch1_ref_s <= 2'h0;
            ch2_ref_s <= 2'h0;
            cap1_s <= 2'h0;
            cap2_s <= 2'h0;
            cap1_prev_q <= 1'b0;
            cap2_prev_q <= 1'b0;
        end else begin
            ch1_ref_s <= {ch1_ref_s[0], CH1_REF_I};
            ch2_ref_s <= {ch2_ref_s[0], CH2_REF_I};
            cap1_s <= {cap1_s[0], CH1_CAPTURE_I};
            cap2_s <= {cap2_s[0], CH2_CAPTURE_I};
            cap1_prev_q <= cap1_s[1];
            cap2_prev_q <= cap2_s[1];
        end
    end

    // ==========================================================
    // registers and counter
    always_comb begin
        chan_en_d = chan_en_q;
        divider_value_d = divider_value_q;
        reload_value_d = reload_value_q;
        config_d = config_q;
        count_value_d = count_value_q;
        if (counter_tick_clock && reload_value_q != '0) begin
            if (count_value_q >= reload_value_q) begin
                count_value_d = '0;
            end else begin
                count_value_d = count_value_q + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
        if (wr_en) begin
            case (PADDR_I)
                CHAN_EN_OFS: begin
                    chan_en_d = PWDATA_I[15:0] & CHAN_EN_MASK;
                    if (config_q[LOCK_LSB+1]) begin
                        chan_en_d[CH1_COMP_POL_BIT] = chan_en_q[CH1_COMP_POL_BIT];
                    end
                end
                // software write wins over a tick in the same cycle
                COUNT_OFS: count_value_d = PWDATA_I[CNT_WIDTH-1:0];
                DIVIDER_OFS: divider_value_d = PWDATA_I[15:0];
                RELOAD_OFS: reload_value_d = PWDATA_I[CNT_WIDTH-1:0];
                CONFIG_OFS: config_d = PWDATA_I[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // capture, gated by channel enable in input mode
    always_comb begin
        cap1_d = cap1_q;
        cap2_d = cap2_q;
        if (config_q[CH1_IN_BIT] && chan_en_q[CH1_OUT_EN_BIT] &&
            (pol_apply(cap1_s[1], chan_en_q[CH1_OUT_POL_BIT]) &&
             !pol_apply(cap1_prev_q, chan_en_q[CH1_OUT_POL_BIT]))) begin
            cap1_d = count_value_q;
        end
        if (config_q[CH2_IN_BIT] && chan_en_q[CH2_OUT_EN_BIT] &&
            (pol_apply(cap2_s[1], chan_en_q[CH2_OUT_POL_BIT]) &&
             !pol_apply(cap2_prev_q, chan_en_q[CH2_OUT_POL_BIT]))) begin
            cap2_d = count_value_q;
        end
    end

    // ==========================================================
    // outputs; disabled output rests at its inactive level
    always_comb begin
        out_d[0] = pol_apply(ch1_ref_s[1] & chan_en_q[CH1_OUT_EN_BIT],
            chan_en_q[CH1_OUT_POL_BIT]);
        out_d[1] = pol_apply(!ch1_ref_s[1] & chan_en_q[CH1_COMP_EN_BIT],
            chan_en_q[CH1_COMP_POL_BIT]);
        out_d[2] = pol_apply(ch2_ref_s[1] & chan_en_q[CH2_OUT_EN_BIT],
            chan_en_q[CH2_OUT_POL_BIT]);
        // no channel 2 complementary enable exists; polarity sets its idle level
        out_d[3] = pol_apply(1'b0, chan_en_q[CH2_COMP_POL_BIT]);
        out_d[4] = chan_en_q[CH1_OUT_EN_BIT] && !config_q[CH1_IN_BIT];
        out_d[5] = chan_en_q[CH1_COMP_EN_BIT] && !config_q[CH1_IN_BIT];
        out_d[6] = chan_en_q[CH2_OUT_EN_BIT] && !config_q[CH2_IN_BIT];
    end

    // ==========================================================
    // read data
    always_comb begin
        rdata_d = 32'h00000000;
        case (PADDR_I)
            CHAN_EN_OFS: rdata_d[15:0] = chan_en_q;
            COUNT_OFS: rdata_d[CNT_WIDTH-1:0] = count_value_q;
            DIVIDER_OFS: rdata_d[15:0] = divider_value_q;
            RELOAD_OFS: rdata_d[CNT_WIDTH-1:0] = reload_value_q;
            CONFIG_OFS: rdata_d[3:0] = config_q;
            default: rdata_d = 32'h00000000;
        endcase
        slverr_d = PSEL_I && !PENABLE_I && !known;
    end

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            chan_en_q <= CHAN_EN_RST;
            count_value_q <= COUNT_RST;
            divider_value_q <= DIVIDER_RST;
            reload_value_q <= RELOAD_RST;
            config_q <= CONFIG_RST;
            cap1_q <= '0;
            cap2_q <= '0;
            out_q <= 7'h00;
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
            PREADY_O <= 1'b0;
            COUNTER_TICK_O <= 1'b0;
        end else begin
            chan_en_q <= chan_en_d;
            count_value_q <= count_value_d;
            divider_value_q <= divider_value_d;
            reload_value_q <= reload_value_d;
            config_q <= config_d;
            cap1_q <= cap1_d;
            cap2_q <= cap2_d;
            out_q <= out_d;
            if (rd_en) begin
                PRDATA_O <= rdata_d;
            end
            if (PSEL_I && !PENABLE_I) begin
                PSLVERR_O <= slverr_d;
            end
            PREADY_O <= PSEL_I && !PENABLE_I;
            COUNTER_TICK_O <= counter_tick_clock;
        end
    end

    assign CH1_MAIN_OUTPUT_O = out_q[0];
    assign CH1_COMPLEMENTARY_OUTPUT_O = out_q[1];
    assign CH2_MAIN_OUTPUT_O = out_q[2];
    assign CH2_COMPLEMENTARY_OUTPUT_O = out_q[3];
    assign CH1_OUTPUT_OE_O = out_q[4];
    assign CH1_COMP_OUTPUT_OE_O = out_q[5];
    assign CH2_OUTPUT_OE_O = out_q[6];
    assign CH1_CAPTURE_VALUE_O = cap1_q;
    assign CH2_CAPTURE_VALUE_O = cap2_q;
endmodule : tbce_timer

// *** tbce_pkg.sv ***
// tbce_pkg: register map, field positions and reset values of the timer base block
// assumes a 32-bit apb slave with byte addresses, one register per aligned word
package tbce_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] CHAN_EN_OFS = 8'h20;
    localparam logic [7:0] COUNT_OFS = 8'h24;
    localparam logic [7:0] DIVIDER_OFS = 8'h28;
    localparam logic [7:0] RELOAD_OFS = 8'h2C;
    localparam logic [7:0] CONFIG_OFS = 8'h30;
    // ==========================================================
    // channel enable field positions
    localparam int CH1_OUT_EN_BIT = 0;
    localparam int CH1_OUT_POL_BIT = 1;
    localparam int CH1_COMP_EN_BIT = 2;
    localparam int CH1_COMP_POL_BIT = 3;
    localparam int CH2_OUT_EN_BIT = 4;
    localparam int CH2_OUT_POL_BIT = 5;
    localparam int CH2_COMP_POL_BIT = 7;
    localparam logic [15:0] CHAN_EN_MASK = 16'h00BF;
    // ==========================================================
    // config register fields: lock level, channel directions
    localparam int LOCK_LSB = 0;
    localparam int CH1_IN_BIT = 2;
    localparam int CH2_IN_BIT = 3;
    // ==========================================================
    // reset values
    localparam logic [15:0] CHAN_EN_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] DIVIDER_RST = 16'h0000;
    localparam logic [15:0] RELOAD_RST = 16'hFFFF;
    localparam logic [3:0] CONFIG_RST = 4'h0;
endpackage : tbce_pkg

// *** tbce_prescaler.sv ***
// tbce_prescaler: divides the core clock by divider value plus one
// assumes divider value comes from a register on the same clock
`timescale 1ns/100ps
module tbce_prescaler #(
    parameter int WIDTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] div_i,
    output logic tick_o
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic tick_d;
    logic tick_q;

    // ==========================================================
    // divider
    always_comb begin
        // a shrinking divider restarts at once instead of running to the old limit
        if (cnt_q >= div_i) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
endmodule : tbce_prescaler

// *** tbce_timer_monitor.sv ***
// tbce_timer_monitor: port checks of the timer base block
// assumes reference pins stay put while a register setting settles
`timescale 1ns/100ps
module tbce_timer_monitor
    import tbce_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic CH1_REF_I,
    input wire logic CH2_REF_I,
    input wire logic CH1_MAIN_OUTPUT_O,
    input wire logic CH1_COMPLEMENTARY_OUTPUT_O,
    input wire logic CH2_MAIN_OUTPUT_O,
    input wire logic CH2_COMPLEMENTARY_OUTPUT_O,
    input wire logic CH1_OUTPUT_OE_O,
    input wire logic CH1_COMP_OUTPUT_OE_O,
    input wire logic CH2_OUTPUT_OE_O
);
    // ========
    // shadow of written settings; quiet counts settle time
    logic [15:0] en_q, en_d;
    logic [3:0] cfg_q, cfg_d;
    logic [2:0] quiet_q, quiet_d;
    logic wr_en, wr_cfg;
    always_comb begin
        wr_en = PREADY_O && PWRITE_I && PADDR_I == CHAN_EN_OFS;
        wr_cfg = PREADY_O && PWRITE_I && PADDR_I == CONFIG_OFS;
        cfg_d = wr_cfg ? PWDATA_I[3:0] : cfg_q;
        quiet_d = (wr_en || wr_cfg) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
        en_d = wr_en ? PWDATA_I[15:0] & CHAN_EN_MASK : en_q;
        if (wr_en && cfg_q[1:0] >= 2'h2) en_d[3] = en_q[3];
    end
    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            en_q <= CHAN_EN_RST;
            cfg_q <= CONFIG_RST;
            quiet_q <= 3'h0;
        end else begin
            en_q <= en_d;
            cfg_q <= cfg_d;
            quiet_q <= quiet_d;
        end
    end
    // ========
    // assertions
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    AST_READY_IN_ACCESS: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access phase");
    AST_READY_ONE: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
    AST_READY_BOUND: assert property ($rose(PENABLE_I) && PSEL_I |-> ##[0:1] PREADY_O)
        else $error("ready late");
    AST_UNMAPPED: assert property (PREADY_O && !(PADDR_I inside {8'h20, 8'h24, 8'h28,
        8'h2C, 8'h30}) |-> PSLVERR_O) else $error("no error on unmapped address");
    AST_CH1_OE: assert property (quiet_q == 3'h7 |-> CH1_OUTPUT_OE_O == (en_q[0] && !cfg_q[2]))
        else $error("ch1 enable wrong");
    AST_CH1_COMP_OE: assert property (quiet_q == 3'h7 |-> CH1_COMP_OUTPUT_OE_O == (en_q[2] && !cfg_q[2]))
        else $error("ch1 comp enable wrong");
    AST_CH2_OE: assert property (quiet_q == 3'h7 |-> CH2_OUTPUT_OE_O == (en_q[4] && !cfg_q[3]))
        else $error("ch2 enable wrong");
    AST_CH1_MAIN: assert property (quiet_q == 3'h7 && !cfg_q[2] |->
        CH1_MAIN_OUTPUT_O == ((en_q[0] & CH1_REF_I) ^ en_q[1])) else $error("ch1 level");
    AST_CH1_COMP: assert property (quiet_q == 3'h7 && !cfg_q[2] |->
        CH1_COMPLEMENTARY_OUTPUT_O == ((en_q[2] & !CH1_REF_I) ^ en_q[3])) else $error("ch1n");
    AST_CH2_MAIN: assert property (quiet_q == 3'h7 && !cfg_q[3] |->
        CH2_MAIN_OUTPUT_O == ((en_q[4] & CH2_REF_I) ^ en_q[5])) else $error("ch2 level");
    AST_CH2_COMP: assert property (quiet_q == 3'h7 && !cfg_q[3] |->
        CH2_COMPLEMENTARY_OUTPUT_O == en_q[7]) else $error("ch2n level");
    cover property (wr_en);
    cover property (PREADY_O && PSLVERR_O);
    cover property (quiet_q == 3'h7 && en_q[0] && !cfg_q[2]);
endmodule : tbce_timer_monitor

// *** tbce_timer_tb.sv ***
// tbce_timer_tb: register, lock, output and tick checks of the timer block
// assumes tbce_timer at its default width, driven by a local apb master
`timescale 1ns/100ps
module tbce_timer_tb
    import tbce_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} tbce_row_type;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, m1, c1, m2, c2, oe1, oe1n, oe2, tick;
    int num_errors = 0, n_compared = 0, t = 0;
    // reload zero first so the counter holds still
    tbce_row_type rows [5] = '{'{RELOAD_OFS, 32'h0, 32'h0}, '{COUNT_OFS, 32'h1234, 32'h1234},
        '{DIVIDER_OFS, 32'hFFFF0001, 32'h1}, '{CHAN_EN_OFS, 32'hFFFFFFFF, 32'hBF},
        '{CONFIG_OFS, 32'hC, 32'hC}};
    logic [7:0] rofs [4] = '{CHAN_EN_OFS, DIVIDER_OFS, RELOAD_OFS, CONFIG_OFS};
    logic [31:0] rexp [4] = '{32'h0, 32'h0, 32'hFFFF, 32'h0};
    always #10 clk = ~clk;
    tbce_timer tbce_timer_i (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata), .CH1_REF_I(1'h1),
        .CH2_REF_I(1'h0), .CH1_CAPTURE_I(1'h0), .CH2_CAPTURE_I(1'h0), .CH1_MAIN_OUTPUT_O(m1),
        .CH1_COMPLEMENTARY_OUTPUT_O(c1), .CH2_MAIN_OUTPUT_O(m2),
        .CH2_COMPLEMENTARY_OUTPUT_O(c2), .CH1_OUTPUT_OE_O(oe1), .CH1_COMP_OUTPUT_OE_O(oe1n),
        .CH2_OUTPUT_OE_O(oe2), .CH1_CAPTURE_VALUE_O(), .CH2_CAPTURE_VALUE_O(),
        .COUNTER_TICK_O(tick));
    // ========
    // tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic [31:0] w, input logic wr);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // ========
    // sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, 1'h1);
            apb(rows[i].a, 32'h0, 1'h0);
            chk(rd, rows[i].r);
        end
        $display("register table done");
        repeat (20) @(posedge clk);
        apb(COUNT_OFS, 32'h0, 1'h0);
        chk(rd, 32'h1234);
        repeat (40) @(posedge clk) t += int'(tick === 1'h1);
        chk(t, 32'd20);
        // small limit: counter must wrap and never pass it
        apb(RELOAD_OFS, 32'h2, 1'h1);
        repeat (20) @(posedge clk);
        apb(COUNT_OFS, 32'h0, 1'h0);
        chk({31'h0, rd > 32'h2}, 32'h0);
        $display("counter done");
        apb(CONFIG_OFS, 32'h2, 1'h1);
        // bit 3 is set from the table; a locked clear must leave it set
        apb(CHAN_EN_OFS, 32'h0, 1'h1);
        apb(CHAN_EN_OFS, 32'h0, 1'h0);
        chk(rd, 32'h8);
        apb(CONFIG_OFS, 32'h0, 1'h1);
        apb(CHAN_EN_OFS, 32'h3B, 1'h1);
        apb(CHAN_EN_OFS, 32'h0, 1'h0);
        chk(rd, 32'h3B);
        repeat (8) @(posedge clk);
        chk({26'h0, m1, c1, oe1, oe1n, m2, oe2}, 32'h1B);
        $display("lock and outputs done");
        apb(8'h3C, 32'h5, 1'h0);
        chk({rd[30:0], er}, 32'h1);
        rst_n <= 1'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        foreach (rofs[i]) begin
            apb(rofs[i], 32'h0, 1'h0);
            chk(rd, rexp[i]);
        end
        $display("reset done");
        results();
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
endmodule : tbce_timer_tb
bind tbce_timer tbce_timer_monitor tbce_timer_monitor_i (.*);
